// ===== design/inductive_scan_config.sv
// Configuration registers, channel schedule control and interrupt pin of the inductive scan converter.
`timescale 1ns/1ns
// Summary of operation
// - Without cycling, convert continuously on the channel the two-bit selected_channel field names.
// - Low-power hold bit set means sleep; cleared means active; reset value is set.
// - Drive override set applies the programmed per-channel drive current during conversion.
// - Startup choice 0 uses full current activation; 1, the default, uses programmed current.
// - Amplitude tracking off disables correction and freezes the measured initial drive.
// - Timebase origin 0 selects internal oscillator; 1 selects the external timebase pin.
// - With mute clear, status updates pull the interrupt pin low; muted holds it high.
// - Boost drives channel 0 above normal current; host must not combine with cycling.
// - Cycling clear converts one selected channel; set runs the cycle_order sequence.
// - Cycling converts each listed channel once, then restarts the order forever.
// - Filter bandwidth codes 001, 100, 101, 111 select 1, 3.3, 10, 33 MHz.
// - With data-ready routing set, each data-ready event sets status and, with mute clear, pulls the pin.
module inductive_scan_config #(
    parameter int NUM_CHANNELS = 4
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [inductive_scan_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [inductive_scan_pkg::DATA_W-1:0] reg_wdata,
    output logic [inductive_scan_pkg::DATA_W-1:0] reg_rdata,
    input wire logic conv_done,
    input wire logic data_ready_irq_route,
    input wire logic error_event,
    input wire logic status_read,
    input wire logic ext_timebase_pin,
    input wire logic int_osc_clk,
    output logic timebase_clk,
    output logic timebase_origin,
    output logic conv_start,
    output logic [1:0] active_channel,
    output inductive_scan_pkg::drive_ctrl_t drive_ctrl,
    output logic [2:0] filter_bandwidth,
    output logic data_ready_status,
    output logic irq_n_pin
);
    import inductive_scan_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    conv_cfg_t conv_cfg_q;
    seq_cfg_t seq_cfg_q;
    logic [DATA_W-1:0] rdata_q;
    logic drdy_q;
    logic err_q;
    logic irq_n_q;
    logic converting;
    drive_ctrl_t drive_q;

    wire logic conv_cfg_hit = (reg_addr == CONV_CFG_ADDR);
    wire logic seq_cfg_hit = (reg_addr == SEQ_CFG_ADDR);
    wire logic conv_cfg_we = reg_we && conv_cfg_hit;
    wire logic seq_cfg_we = reg_we && seq_cfg_hit;
    // Write data viewed through the field layouts.
    wire conv_cfg_t wr_conv = conv_cfg_t'(reg_wdata);
    wire seq_cfg_t wr_seq = seq_cfg_t'(reg_wdata);
    // Unmapped addresses read as zero.
    wire logic [DATA_W-1:0] rd_mux = conv_cfg_hit ? DATA_W'(conv_cfg_q) :
                                     seq_cfg_hit ? DATA_W'(seq_cfg_q) : '0;

    // Reserved fields keep what the host wrote, so a readback shows its own values.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            conv_cfg_q <= conv_cfg_t'(CONV_CFG_RESET);
            seq_cfg_q <= seq_cfg_t'(SEQ_CFG_RESET);
        end else begin
            if (conv_cfg_we) begin
                conv_cfg_q <= wr_conv;
            end
            if (seq_cfg_we) begin
                seq_cfg_q <= wr_seq;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= '0;
        end else if (reg_re) begin
            rdata_q <= rd_mux;
        end
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Schedule
    // ------------------------------------------------------------
    scan_sequencer #(
        .NUM_CHANNELS(NUM_CHANNELS)
    ) u_seq (
        .core_clk(core_clk),
        .nrst(nrst),
        .hold(conv_cfg_q.low_power_hold),
        .cycling(seq_cfg_q.multi_channel_cycling),
        .sel_channel(conv_cfg_q.selected_channel),
        .order(seq_cfg_q.cycle_order),
        .conv_done(conv_done),
        .conv_start(conv_start),
        .converting(converting),
        .chan_q(active_channel)
    );

    // ------------------------------------------------------------
    // Sensor drive and timebase
    // ------------------------------------------------------------
    // Boost is only honoured on channel 0; the host keeps it away from cycling mode.
    wire logic boost_now = conv_cfg_q.boost_drive && active_channel == CHAN_0;
    wire drive_ctrl_t drive_d = '{
        sensor_enable: converting && !conv_cfg_q.low_power_hold,
        drive_override: conv_cfg_q.drive_override,
        full_current_activation: !conv_cfg_q.startup_drive_choice,
        amplitude_tracking_on: !conv_cfg_q.amplitude_tracking_off,
        boost_ch0: boost_now && converting
    };

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            drive_q <= '0;
        end else begin
            drive_q <= drive_d;
        end
    end

    assign drive_ctrl = drive_q;
    assign filter_bandwidth = seq_cfg_q.filter_bandwidth;
    assign timebase_origin = conv_cfg_q.timebase_origin;
    // Clock selection is a plain mux; a glitch-free switch belongs to the clock tree.
    assign timebase_clk = (conv_cfg_q.timebase_origin == TIMEBASE_EXTERNAL) ? ext_timebase_pin : int_osc_clk;

    // ------------------------------------------------------------
    // Status and interrupt pin
    // ------------------------------------------------------------
    wire logic drdy_set = conv_done && converting && data_ready_irq_route;
    wire logic status_pending = drdy_q || err_q;
    wire logic irq_n_d = !(status_pending && !conv_cfg_q.irq_pin_mute);

    // A new event in the clearing cycle wins, so no data-ready is lost.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            drdy_q <= 1'b0;
            err_q <= 1'b0;
            irq_n_q <= 1'b1;
        end else begin
            drdy_q <= drdy_set || (drdy_q && !status_read);
            err_q <= error_event || (err_q && !status_read);
            irq_n_q <= irq_n_d;
        end
    end

    assign data_ready_status = drdy_q;
    assign irq_n_pin = irq_n_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_MUTE_HIGH: assert property (@(posedge core_clk) disable iff (!nrst)
        (conv_cfg_q.irq_pin_mute && $past(conv_cfg_q.irq_pin_mute)) |-> irq_n_pin)
        else $error("Interrupt pin low while muted.");
    AST_DRDY_PIN: assert property (@(posedge core_clk) disable iff (!nrst)
        (drdy_set && !conv_cfg_q.irq_pin_mute && !conv_cfg_we) |=> data_ready_status ##1 !irq_n_pin)
        else $error("Data-ready event did not reach status and pin.");
    AST_SLEEP_NO_DRIVE: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(conv_cfg_q.low_power_hold) |-> !drive_ctrl.sensor_enable)
        else $error("Sensor driven during sleep.");
    AST_RESET_SLEEP: assert property (@(posedge core_clk)
        $rose(nrst) |-> conv_cfg_q.low_power_hold && !conv_start) else $error("Device did not start asleep.");
    AST_OVERRIDE_FOLLOW: assert property (@(posedge core_clk) disable iff (!nrst)
        conv_cfg_we |=> ##1 drive_ctrl.drive_override == $past(wr_conv.drive_override, 2))
        else $error("Drive override does not follow the written bit.");
    AST_ACTIVATION_MODE: assert property (@(posedge core_clk) disable iff (!nrst)
        drive_ctrl.full_current_activation != $past(conv_cfg_q.startup_drive_choice))
        else $error("Activation current mode inverted.");
    AST_TRACKING_OFF: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(nrst) |-> drive_ctrl.amplitude_tracking_on == !$past(conv_cfg_q.amplitude_tracking_off))
        else $error("Amplitude tracking does not follow its disable bit.");
    AST_BOOST_CH0: assert property (@(posedge core_clk) disable iff (!nrst)
        drive_ctrl.boost_ch0 |-> $past(active_channel) == CHAN_0 && $past(conv_cfg_q.boost_drive))
        else $error("Boost drive applied outside channel 0.");
    AST_OVERRIDE_OFF: assert property (@(posedge core_clk) disable iff (!nrst)
        !$past(conv_cfg_q.drive_override) |-> !drive_ctrl.drive_override)
        else $error("Drive override active while its bit is clear.");
    AST_BOOST_OFF: assert property (@(posedge core_clk) disable iff (!nrst)
        !$past(conv_cfg_q.boost_drive) |-> !drive_ctrl.boost_ch0)
        else $error("Boost drive active while its bit is clear.");
    AST_TIMEBASE_FOLLOW: assert property (@(posedge core_clk) disable iff (!nrst)
        conv_cfg_we |=> timebase_origin == $past(wr_conv.timebase_origin))
        else $error("Timebase origin does not follow the written bit.");
    AST_BW_FOLLOW: assert property (@(posedge core_clk) disable iff (!nrst)
        seq_cfg_we |=> filter_bandwidth == $past(wr_seq.filter_bandwidth))
        else $error("Filter bandwidth does not follow the written field.");
    AST_SLEEP_STOPS: assert property (@(posedge core_clk) disable iff (!nrst)
        (conv_cfg_we && wr_conv.low_power_hold) |=> ##1 !converting)
        else $error("Conversion still running after sleep was written.");
    AST_WAKE_DRIVE: assert property (@(posedge core_clk) disable iff (!nrst)
        conv_start |=> drive_ctrl.sensor_enable || $past(conv_cfg_q.low_power_hold))
        else $error("Sensor not driven after a conversion start.");
    AST_CHAN_ON_START: assert property (@(posedge core_clk) disable iff (!nrst)
        $changed(active_channel) |-> conv_start)
        else $error("Active channel changed without a conversion start.");

    // ------------------------------------------------------------
    // Status checks
    // ------------------------------------------------------------
    AST_DRDY_SET_WINS: assert property (@(posedge core_clk) disable iff (!nrst)
        drdy_set |=> data_ready_status)
        else $error("Data-ready event lost.");
    AST_DRDY_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst)
        (status_read && !drdy_set) |=> !data_ready_status)
        else $error("Data-ready flag survived a status read.");
    AST_PIN_ASSERT: assert property (@(posedge core_clk) disable iff (!nrst)
        (status_pending && !conv_cfg_q.irq_pin_mute) |=> !irq_n_pin)
        else $error("Pending status did not pull the interrupt pin low.");
    AST_PIN_IDLE: assert property (@(posedge core_clk) disable iff (!nrst)
        !status_pending |=> irq_n_pin)
        else $error("Interrupt pin low with nothing pending.");
    AST_ERR_PIN: assert property (@(posedge core_clk) disable iff (!nrst)
        (error_event && !conv_cfg_q.irq_pin_mute && !conv_cfg_we) |=> ##1 !irq_n_pin)
        else $error("Error event did not reach the interrupt pin.");

endmodule

// ===== design/inductive_scan_pkg.sv
// Package with register map, field layouts, reset values and codes of the scan configuration block.
package inductive_scan_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [7:0] CONV_CFG_ADDR = 8'h1a;
    localparam logic [7:0] SEQ_CFG_ADDR = 8'h1b;

    // ------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] selected_channel;
        logic low_power_hold;
        logic drive_override;
        logic startup_drive_choice;
        logic amplitude_tracking_off;
        logic timebase_origin;
        logic rsvd_bit8;
        logic irq_pin_mute;
        logic boost_drive;
        logic [5:0] rsvd_low;
    } conv_cfg_t;

    typedef struct packed {
        logic multi_channel_cycling;
        logic [1:0] cycle_order;
        logic [9:0] rsvd_mid;
        logic [2:0] filter_bandwidth;
    } seq_cfg_t;

    // Drive controls handed to the sensor front end.
    typedef struct packed {
        logic sensor_enable;
        logic drive_override;
        logic full_current_activation;
        logic amplitude_tracking_on;
        logic boost_ch0;
    } drive_ctrl_t;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] CONV_CFG_RESET = 16'h2801;
    localparam logic [15:0] SEQ_CFG_RESET = 16'h020f;

    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    localparam logic [1:0] ORDER_CH01 = 2'b00;
    localparam logic [1:0] ORDER_CH012 = 2'b01;
    localparam logic [1:0] ORDER_CH0123 = 2'b10;
    localparam logic [1:0] ORDER_CH01_ALT = 2'b11;
    localparam logic [1:0] CHAN_0 = 2'b00;
    localparam logic [1:0] CHAN_1 = 2'b01;
    localparam logic [1:0] CHAN_2 = 2'b10;
    localparam logic [1:0] CHAN_3 = 2'b11;
    localparam logic [2:0] BW_1MHZ = 3'b001;
    localparam logic [2:0] BW_3P3MHZ = 3'b100;
    localparam logic [2:0] BW_10MHZ = 3'b101;
    localparam logic [2:0] BW_33MHZ = 3'b111;
    localparam logic TIMEBASE_INTERNAL = 1'b0;
    localparam logic TIMEBASE_EXTERNAL = 1'b1;

    // Last channel of a cycling order, clamped to the channels present.
    function automatic logic [1:0] last_channel(input logic [1:0] order, input logic [1:0] top);
        logic [1:0] last;
        last = CHAN_1;
        case (order)
            ORDER_CH012: last = CHAN_2;
            ORDER_CH0123: last = CHAN_3;
            default: last = CHAN_1;
        endcase
        last_channel = (last > top) ? top : last;
    endfunction

endpackage

// ===== design/scan_sequencer.sv
// Conversion scheduler that walks the single or cycling channel schedule.
`timescale 1ns/1ns
module scan_sequencer #(
    parameter int NUM_CHANNELS = 4
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic hold,
    input wire logic cycling,
    input wire logic [1:0] sel_channel,
    input wire logic [1:0] order,
    input wire logic conv_done,
    output logic conv_start,
    output logic converting,
    output logic [1:0] chan_q
);
    import inductive_scan_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_LAUNCH, S_WAIT} seq_state_t;

    localparam logic [1:0] TOP_CHAN = 2'(NUM_CHANNELS - 1);

    seq_state_t state_q;
    seq_state_t state_d;
    logic [1:0] chan_d;
    wire logic [1:0] single_chan = (sel_channel > TOP_CHAN) ? TOP_CHAN : sel_channel;
    wire logic [1:0] last_chan = last_channel(order, TOP_CHAN);
    wire logic [1:0] first_chan = cycling ? CHAN_0 : single_chan;
    wire logic [1:0] next_chan = !cycling ? single_chan : (chan_q >= last_chan) ? CHAN_0 : 2'(chan_q + 2'd1);

    assign conv_start = (state_q == S_LAUNCH);
    assign converting = (state_q != S_IDLE);

    // ------------------------------------------------------------
    // Schedule
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        chan_d = chan_q;
        case (state_q)
            S_IDLE: begin
                if (!hold) begin
                    state_d = S_LAUNCH;
                    chan_d = first_chan;
                end
            end
            S_LAUNCH: begin
                state_d = hold ? S_IDLE : S_WAIT;
            end
            S_WAIT: begin
                if (hold) begin
                    state_d = S_IDLE;
                end else if (conv_done) begin
                    state_d = S_LAUNCH;
                    chan_d = next_chan;
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= S_IDLE;
            chan_q <= CHAN_0;
        end else begin
            state_q <= state_d;
            chan_q <= chan_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_HOLD_NO_START: assert property (@(posedge core_clk) disable iff (!nrst)
        hold |=> !conv_start) else $error("Conversion launched while held in sleep.");
    AST_CYCLE_WRAP: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_q == S_WAIT && conv_done && !hold && cycling && chan_q >= last_chan)
        |=> conv_start && chan_q == CHAN_0) else $error("Cycling order did not restart at channel 0.");
    AST_CYCLE_STEP: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_q == S_WAIT && conv_done && !hold && cycling && chan_q < last_chan)
        |=> chan_q == $past(chan_q) + 2'd1) else $error("Cycling order skipped a channel.");
    AST_SINGLE_CHAN: assert property (@(posedge core_clk) disable iff (!nrst)
        (conv_start && !$past(cycling)) |-> chan_q == $past(single_chan))
        else $error("Single channel mode converted the wrong channel.");
    AST_WAKE_START: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_q == S_IDLE && !hold) |=> conv_start) else $error("No conversion one cycle after wake.");

endmodule

// ===== tb/conv_core_model.sv
// Behavioural converter core that finishes each started conversion after a set delay.
`timescale 1ns/1ns
module conv_core_model (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic conv_start,
    input wire logic [3:0] delay,
    output logic conv_done
);
    logic [4:0] cnt_q;
    // Done never comes in the start cycle itself; a restart reloads the count and drops a stale done.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 5'h00;
            conv_done <= 1'b0;
        end else begin
            conv_done <= (cnt_q == 5'h01) && !conv_start;
            if (conv_start) begin
                cnt_q <= {1'b0, delay} + 5'h01;
            end else if (cnt_q != 5'h00) begin
                cnt_q <= cnt_q - 5'h01;
            end
        end
    end
endmodule

// ===== tb/inductive_scan_config_tb.sv
// Self-checking bench for the scan configuration block with a converter core model.
`timescale 1ns/1ns
module inductive_scan_config_tb;
    import inductive_scan_pkg::*;
    logic core_clk = 1'b0, nrst = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic route = 1'b0, status_read = 1'b0, ext_pin = 1'b0, osc = 1'b0, err = 1'b0;
    logic conv_done, timebase_clk, timebase_origin, conv_start, drdy, irq_n, tb;
    logic [1:0] active_channel, ch, sel, ord;
    logic [2:0] filter_bandwidth;
    logic [2:0] bw_tab [4] = '{BW_1MHZ, BW_3P3MHZ, BW_10MHZ, BW_33MHZ};
    logic [3:0] delay = 4'h2, f;
    drive_ctrl_t drive_ctrl;
    int n_fail = 0, n_tests = 0, cycles = 0, n_starts = 0;
    always #20 core_clk = ~core_clk;
    inductive_scan_config #(.NUM_CHANNELS(4)) inductive_scan_config_inst (.core_clk(core_clk), .nrst(nrst),
        .reg_addr(reg_addr), .reg_we(reg_we), .reg_re(reg_re), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .conv_done(conv_done), .data_ready_irq_route(route), .error_event(err), .status_read(status_read),
        .ext_timebase_pin(ext_pin), .int_osc_clk(osc), .timebase_clk(timebase_clk),
        .timebase_origin(timebase_origin), .conv_start(conv_start), .active_channel(active_channel),
        .drive_ctrl(drive_ctrl), .filter_bandwidth(filter_bandwidth), .data_ready_status(drdy), .irq_n_pin(irq_n));
    conv_core_model conv_core_model_inst (.core_clk(core_clk), .nrst(nrst), .conv_start(conv_start),
        .delay(delay), .conv_done(conv_done));
    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (conv_start === 1'b1) begin
            n_starts <= n_starts + 1;
        end
        if (cycles == 6000) begin
            n_fail = n_fail + 1;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        cyc(1);
        reg_addr = a;
        reg_wdata = d;
        reg_we = 1'b1;
        cyc(1);
        reg_we = 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        cyc(1);
        reg_addr = a;
        reg_re = 1'b1;
        cyc(1);
        reg_re = 1'b0;
        check(reg_rdata, e);
    endtask
    // Host keeps the reserved bits at their documented patterns on every write.
    // Boost is only ever asked for while cycling is off.
    function automatic logic [15:0] cfg(input logic [1:0] s, input logic h, input logic [3:0] fl, input logic m,
        input logic b);
        return {s, h, fl, 1'b0, m, b, 6'h01};
    endfunction
    function automatic logic [1:0] exp_chan(input logic [1:0] o, input int i);
        if (o == ORDER_CH012) return 2'(i % 3);
        if (o == ORDER_CH0123) return 2'(i % 4);
        return 2'(i % 2);
    endfunction
    task automatic wait_start(output logic [1:0] c);
        int k;
        k = 0;
        c = 2'bxx;
        while (k < 100) begin
            @(negedge core_clk);
            if (conv_start === 1'b1) begin
                c = active_channel;
                k = 100;
            end
            k++;
        end
        delay = 4'($urandom_range(1, 9));
    endtask
    task automatic sleep(input logic m);
        wr(CONV_CFG_ADDR, cfg(2'b00, 1'b1, 4'h8, m, 1'b0));
        cyc(2);
        check(16'(drive_ctrl.sensor_enable), 16'h0000);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        delay = 4'($urandom(51632) % 9 + 1);
        cyc(3);
        nrst = 1'b1;
        rdc(CONV_CFG_ADDR, 16'h2801);
        rdc(SEQ_CFG_ADDR, 16'h020f);
        rdc(8'h1c, 16'h0000);
        check(16'(irq_n), 16'h0001);
        cyc(20);
        check(16'(n_starts), 16'h0000);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            tb = i[0];
            wr(SEQ_CFG_ADDR, {3'b000, 10'h041, bw_tab[i]});
            wr(CONV_CFG_ADDR, cfg(2'b00, 1'b1, {3'b000, tb}, 1'b0, 1'b0));
            rdc(SEQ_CFG_ADDR, {3'b000, 10'h041, bw_tab[i]});
            rdc(CONV_CFG_ADDR, cfg(2'b00, 1'b1, {3'b000, tb}, 1'b0, 1'b0));
            check(16'(filter_bandwidth), 16'(bw_tab[i]));
            check(16'(timebase_origin), 16'(tb));
            ext_pin = 1'($urandom);
            osc = ~ext_pin;
            #1;
            check(16'(timebase_clk), 16'(tb ? ext_pin : osc));
        end
        $display("timebase and filter test done");
        for (int s = 0; s < 4; s++) begin
            f = 4'($urandom);
            sleep(1'b0);
            wr(CONV_CFG_ADDR, cfg(2'(s), 1'b0, f, 1'b0, 1'b1));
            wait_start(ch);
            check(16'(ch), 16'(s));
            @(negedge core_clk);
            check(16'(drive_ctrl), 16'({1'b1, f[3], ~f[2], ~f[1], s == 0}));
        end
        $display("single channel test done");
        for (int o = 0; o < 4; o++) begin
            ord = 2'(o);
            sel = 2'($urandom);
            sleep(1'b0);
            wr(SEQ_CFG_ADDR, {1'b1, ord, 10'h041, BW_33MHZ});
            wr(CONV_CFG_ADDR, cfg(sel, 1'b0, 4'h8, 1'b0, 1'b0));
            for (int i = 0; i < 6; i++) begin
                wait_start(ch);
                check(16'(ch), 16'(exp_chan(ord, i)));
            end
        end
        $display("cycling test done");
        sleep(1'b0);
        wr(SEQ_CFG_ADDR, SEQ_CFG_RESET);
        route = 1'b1;
        wr(CONV_CFG_ADDR, cfg(2'b00, 1'b0, 4'h8, 1'b0, 1'b0));
        wait_start(ch);
        cyc(14);
        check(16'(drdy), 16'h0001);
        check(16'(irq_n), 16'h0000);
        sleep(1'b0);
        status_read = 1'b1;
        cyc(1);
        status_read = 1'b0;
        cyc(3);
        check(16'({drdy, irq_n}), 16'h0001);
        err = 1'b1;
        cyc(1);
        err = 1'b0;
        cyc(1);
        check(16'(irq_n), 16'h0000);
        status_read = 1'b1;
        cyc(1);
        status_read = 1'b0;
        cyc(1);
        check(16'(irq_n), 16'h0001);
        wr(CONV_CFG_ADDR, cfg(2'b00, 1'b0, 4'h8, 1'b1, 1'b0));
        wait_start(ch);
        cyc(14);
        check(16'({drdy, irq_n}), 16'h0003);
        $display("interrupt test done");
        report_and_stop();
    end
endmodule
